//--- csie_defines.svh
`ifndef CSIE_DEFINES_SVH
`define CSIE_DEFINES_SVH

`define CSIE_OP_MUL8      8'h01
`define CSIE_OP_DIV16     8'h11
`define CSIE_OP_LDI       8'h04
`define CSIE_OP_LDDIR     8'h05
`define CSIE_OP_LDWI      8'hE4
`define CSIE_OP_JMPA      8'hE0
`define CSIE_OP_RDPC      8'hF0
`define CSIE_OP_SWPC      8'hF4
`define CSIE_OP_BNZ       8'hFC
`define CSIE_OP_BZ        8'hFD
`define CSIE_OP_BIT_HI    5'h14
`define CSIE_OP_BSET_HI   5'h15
`define CSIE_OP_VCALL_HI  5'h1D

`define CSIE_VEC_BASE     16'hFFC0
`define CSIE_PC_RESET     16'h0000
`define CSIE_SP_RESET     16'h0280
`define CSIE_PAGE0_HI     8'h00
`define CSIE_PORT_ADDR    16'h0000
`define CSIE_IRQ_ADDR     16'h0001
`define CSIE_MUL_STEPS    5'h08
`define CSIE_DIV_STEPS    5'h10

`endif

//--- csie_pkg.sv
`default_nettype none
package csie_pkg;

  typedef enum logic [3:0] {
    ST_FETCH  = 4'h0,
    ST_OPR1   = 4'h1,
    ST_OPR2   = 4'h2,
    ST_LDDIR  = 4'h3,
    ST_RMW_RD = 4'h4,
    ST_RMW_WR = 4'h5,
    ST_STK_H  = 4'h6,
    ST_STK_L  = 4'h7,
    ST_VEC_H  = 4'h8,
    ST_VEC_L  = 4'h9,
    ST_MULDIV = 4'hA
  } csie_state_t;

  typedef struct packed {
    csie_state_t st;
    logic [15:0] pc;
    logic [15:0] acc;
    logic [15:0] tmp;
    logic [15:0] sp;
    logic        zero;
    logic [7:0]  op;
    logic [7:0]  opr;
    logic [15:0] addr;
    logic [7:0]  wdata;
    logic        rd;
    logic        wr;
    logic        read_modify_write_marker;
    logic [7:0]  latch;
    logic [7:0]  irq;
    logic        md_start;
    logic        md_div;
  } csie_core_t;

  typedef struct packed {
    logic        busy;
    logic        is_div;
    logic [4:0]  cnt;
    logic [15:0] x;
    logic [15:0] y;
    logic [8:0]  r;
    logic [7:0]  d;
    logic        done;
  } csie_md_t;

endpackage : csie_pkg
`default_nettype wire

//--- csie_md_if.sv
`timescale 1ns/1ps
`default_nettype none
interface csie_md_if;
  logic        start;
  logic        is_div;
  logic [15:0] acc_in;
  logic [15:0] tmp_in;
  logic        done;
  logic [15:0] acc_out;
  logic [15:0] tmp_out;
  modport core (output start, output is_div, output acc_in, output tmp_in,
                input done, input acc_out, input tmp_out);
  modport unit (input start, input is_div, input acc_in, input tmp_in,
                output done, output acc_out, output tmp_out);
endinterface : csie_md_if
`default_nettype wire

//--- csie_muldiv.sv
`timescale 1ns/1ps
`default_nettype none
`include "csie_defines.svh"
module csie_muldiv (
  input  wire logic clk,
  input  wire logic rst,
  csie_md_if.unit   md
);
  csie_pkg::csie_md_t s_reg;
  csie_pkg::csie_md_t s_next;
  logic [8:0]         shifted;

  always_comb
  begin
    s_next      = s_reg;
    s_next.done = 1'b0;
    shifted     = {s_reg.r[7:0], s_reg.x[15]};
    if (md.start)
    begin
      s_next.busy   = 1'b1;
      s_next.is_div = md.is_div;
      s_next.cnt    = md.is_div ? `CSIE_DIV_STEPS : `CSIE_MUL_STEPS;
      // the high byte of acc never takes part; tmp keeps its high byte only as the dividend
      s_next.x      = md.is_div ? md.tmp_in : 16'h0000;
      s_next.y      = {8'h00, md.acc_in[7:0]};
      s_next.r      = 9'h000;
      s_next.d      = md.is_div ? md.acc_in[7:0] : md.tmp_in[7:0];
    end
    else if (s_reg.busy)
    begin
      if (s_reg.is_div)
      begin
        // restoring division; quotient above 8 bits is simply truncated
        s_next.x = {s_reg.x[14:0], 1'b0};
        if (shifted >= {1'b0, s_reg.d})
        begin
          s_next.r    = shifted - {1'b0, s_reg.d};
          s_next.x[0] = 1'b1;
        end
        else
        begin
          s_next.r = shifted;
        end
      end
      else
      begin
        if (s_reg.d[0])
        begin
          s_next.x = s_reg.x + s_reg.y;
        end
        s_next.y = {s_reg.y[14:0], 1'b0};
        s_next.d = {1'b0, s_reg.d[7:1]};
      end
      s_next.cnt = s_reg.cnt - 5'h01;
      if (s_reg.cnt == 5'h01)
      begin
        s_next.busy = 1'b0;
        s_next.done = 1'b1;
      end
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      s_reg <= '0;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  assign md.done    = s_reg.done;
  assign md.acc_out = s_reg.is_div ? {8'h00, s_reg.x[7:0]} : s_reg.x;
  assign md.tmp_out = {8'h00, s_reg.r[7:0]};
endmodule : csie_muldiv
`default_nettype wire

//--- csie_core.sv
`timescale 1ns/1ps
`default_nettype none
`include "csie_defines.svh"
module csie_core (
  input  wire logic        clk,
  input  wire logic        rst,
  output logic [15:0]      bus_addr,
  output logic [7:0]       bus_wdata,
  output logic             bus_rd,
  output logic             bus_wr,
  output logic             bus_rmw,
  input  wire logic [7:0]  bus_rdata,
  input  wire logic [7:0]  port_pin_in,
  output logic [7:0]       port_latch_out,
  input  wire logic [7:0]  irq_set,
  output logic [7:0]       irq_flag_out
);
  csie_pkg::csie_core_t s_reg;
  csie_pkg::csie_core_t s_next;
  logic [7:0]           rdv;
  logic [7:0]           mask;
  logic [15:0]          pc1;
  logic [15:0]          target;
  csie_md_if            md ();

  function automatic logic hit_port(input logic [15:0] a);
    hit_port = (a == `CSIE_PORT_ADDR);
  endfunction : hit_port

  function automatic logic hit_irq(input logic [15:0] a);
    hit_irq = (a == `CSIE_IRQ_ADDR);
  endfunction : hit_irq

  function automatic csie_pkg::csie_core_t bus(input csie_pkg::csie_core_t c, input logic [15:0] a,
                                               input logic r, input logic w, input logic m,
                                               input logic [7:0] d);
    bus       = c;
    bus.addr  = a;
    bus.rd    = r;
    bus.wr    = w;
    bus.read_modify_write_marker   = m;
    bus.wdata = d;
  endfunction : bus

  csie_muldiv csie_muldiv_i (
    .clk (clk),
    .rst (rst),
    .md  (md)
  );

  assign md.start  = s_reg.md_start;
  assign md.is_div = s_reg.md_div;
  assign md.acc_in = s_reg.acc;
  assign md.tmp_in = s_reg.tmp;

  // read data as seen by the core in the current read cycle
  always_comb
  begin
    if (hit_port(s_reg.addr))
    begin
      rdv = s_reg.read_modify_write_marker ? s_reg.latch : port_pin_in;
    end
    else if (hit_irq(s_reg.addr))
    begin
      // ones keep pending requests alive across the write-back
      rdv = s_reg.read_modify_write_marker ? 8'hFF : s_reg.irq;
    end
    else
    begin
      rdv = bus_rdata;
    end
  end

  always_comb
  begin
    s_next          = s_reg;
    s_next.md_start = 1'b0;
    mask            = 8'h01 << s_reg.op[2:0];
    pc1             = s_reg.pc + 16'h0001;
    // pc1 already points past the displacement byte
    target          = pc1 + {{8{bus_rdata[7]}}, bus_rdata};
    s_next          = bus(s_next, s_reg.pc, 1'b0, 1'b0, 1'b0, 8'h00);
    // a new request wins over a software clear in the same cycle
    s_next.irq      = s_reg.irq | irq_set;
    if (s_reg.wr && hit_irq(s_reg.addr))
    begin
      s_next.irq = (s_reg.irq & s_reg.wdata) | irq_set;
    end
    if (s_reg.wr && hit_port(s_reg.addr))
    begin
      s_next.latch = s_reg.wdata;
    end
    case (s_reg.st)
      csie_pkg::ST_FETCH:
      begin
        s_next.op = bus_rdata;
        s_next.pc = pc1;
        s_next.st = csie_pkg::ST_FETCH;
        s_next    = bus(s_next, pc1, 1'b1, 1'b0, 1'b0, 8'h00);
        if (bus_rdata == `CSIE_OP_JMPA)
        begin
          s_next.pc = s_reg.acc;
          s_next    = bus(s_next, s_reg.acc, 1'b1, 1'b0, 1'b0, 8'h00);
        end
        else if (bus_rdata == `CSIE_OP_RDPC)
        begin
          s_next.acc = pc1;
        end
        else if (bus_rdata == `CSIE_OP_SWPC)
        begin
          s_next.acc = pc1;
          s_next.pc  = s_reg.acc;
          s_next     = bus(s_next, s_reg.acc, 1'b1, 1'b0, 1'b0, 8'h00);
        end
        else if (bus_rdata == `CSIE_OP_MUL8 || bus_rdata == `CSIE_OP_DIV16)
        begin
          s_next.md_start = 1'b1;
          s_next.md_div   = (bus_rdata == `CSIE_OP_DIV16);
          s_next.st       = csie_pkg::ST_MULDIV;
          s_next          = bus(s_next, pc1, 1'b0, 1'b0, 1'b0, 8'h00);
        end
        else if (bus_rdata[7:3] == `CSIE_OP_VCALL_HI)
        begin
          s_next.sp = s_reg.sp - 16'h0002;
          s_next.st = csie_pkg::ST_STK_H;
          s_next    = bus(s_next, s_reg.sp - 16'h0002, 1'b0, 1'b1, 1'b0, pc1[15:8]);
        end
        else if (bus_rdata == `CSIE_OP_LDI || bus_rdata == `CSIE_OP_LDDIR || bus_rdata == `CSIE_OP_LDWI ||
                 bus_rdata == `CSIE_OP_BZ || bus_rdata == `CSIE_OP_BNZ || bus_rdata[7:4] == 4'hA)
        begin
          s_next.st = csie_pkg::ST_OPR1;
        end
      end
      csie_pkg::ST_OPR1:
      begin
        s_next.opr = bus_rdata;
        s_next.pc  = pc1;
        s_next.st  = csie_pkg::ST_FETCH;
        s_next     = bus(s_next, pc1, 1'b1, 1'b0, 1'b0, 8'h00);
        if (s_reg.op == `CSIE_OP_LDI)
        begin
          s_next.tmp[7:0] = s_reg.acc[7:0];
          s_next.acc[7:0] = bus_rdata;
          s_next.zero     = (bus_rdata == 8'h00);
        end
        else if (s_reg.op == `CSIE_OP_LDDIR)
        begin
          s_next.st = csie_pkg::ST_LDDIR;
          s_next    = bus(s_next, {`CSIE_PAGE0_HI, bus_rdata}, 1'b1, 1'b0, 1'b0, 8'h00);
        end
        else if (s_reg.op == `CSIE_OP_LDWI)
        begin
          s_next.st = csie_pkg::ST_OPR2;
        end
        else if (s_reg.op[7:3] == `CSIE_OP_BIT_HI || s_reg.op[7:3] == `CSIE_OP_BSET_HI)
        begin
          s_next.st = csie_pkg::ST_RMW_RD;
          s_next    = bus(s_next, {`CSIE_PAGE0_HI, bus_rdata}, 1'b1, 1'b0, 1'b1, 8'h00);
        end
        else if ((s_reg.op == `CSIE_OP_BZ) == s_reg.zero)
        begin
          s_next.pc = target;
          s_next    = bus(s_next, target, 1'b1, 1'b0, 1'b0, 8'h00);
        end
      end
      csie_pkg::ST_OPR2:
      begin
        s_next.tmp  = s_reg.acc;
        s_next.acc  = {s_reg.opr, bus_rdata};
        s_next.zero = ({s_reg.opr, bus_rdata} == 16'h0000);
        s_next.pc   = pc1;
        s_next.st   = csie_pkg::ST_FETCH;
        s_next      = bus(s_next, pc1, 1'b1, 1'b0, 1'b0, 8'h00);
      end
      csie_pkg::ST_LDDIR:
      begin
        s_next.tmp[7:0] = s_reg.acc[7:0];
        s_next.acc[7:0] = rdv;
        s_next.zero     = (rdv == 8'h00);
        s_next.st       = csie_pkg::ST_FETCH;
        s_next          = bus(s_next, s_reg.pc, 1'b1, 1'b0, 1'b0, 8'h00);
      end
      csie_pkg::ST_RMW_RD:
      begin
        s_next.st = csie_pkg::ST_RMW_WR;
        s_next    = bus(s_next, s_reg.addr, 1'b0, 1'b1, 1'b0,
                        s_reg.op[3] ? (rdv | mask) : (rdv & ~mask));
      end
      csie_pkg::ST_RMW_WR:
      begin
        s_next.st = csie_pkg::ST_FETCH;
        s_next    = bus(s_next, s_reg.pc, 1'b1, 1'b0, 1'b0, 8'h00);
      end
      csie_pkg::ST_STK_H:
      begin
        s_next.st = csie_pkg::ST_STK_L;
        s_next    = bus(s_next, s_reg.sp + 16'h0001, 1'b0, 1'b1, 1'b0, s_reg.pc[7:0]);
      end
      csie_pkg::ST_STK_L:
      begin
        s_next.st = csie_pkg::ST_VEC_H;
        s_next    = bus(s_next, `CSIE_VEC_BASE + {12'h000, s_reg.op[2:0], 1'b0},
                        1'b1, 1'b0, 1'b0, 8'h00);
      end
      csie_pkg::ST_VEC_H:
      begin
        s_next.opr = bus_rdata;
        s_next.st  = csie_pkg::ST_VEC_L;
        s_next     = bus(s_next, s_reg.addr + 16'h0001, 1'b1, 1'b0, 1'b0, 8'h00);
      end
      csie_pkg::ST_VEC_L:
      begin
        s_next.pc = {s_reg.opr, bus_rdata};
        s_next.st = csie_pkg::ST_FETCH;
        s_next    = bus(s_next, {s_reg.opr, bus_rdata}, 1'b1, 1'b0, 1'b0, 8'h00);
      end
      csie_pkg::ST_MULDIV:
      begin
        if (md.done)
        begin
          // flags are deliberately left alone
          s_next.acc = md.acc_out;
          if (s_reg.md_div)
          begin
            s_next.tmp = md.tmp_out;
          end
          s_next.st = csie_pkg::ST_FETCH;
          s_next    = bus(s_next, s_reg.pc, 1'b1, 1'b0, 1'b0, 8'h00);
        end
      end
      default:
      begin
        s_next.st = csie_pkg::ST_FETCH;
        s_next    = bus(s_next, s_reg.pc, 1'b1, 1'b0, 1'b0, 8'h00);
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      s_reg      <= '0;
      s_reg.st   <= csie_pkg::ST_FETCH;
      s_reg.pc   <= `CSIE_PC_RESET;
      s_reg.addr <= `CSIE_PC_RESET;
      s_reg.sp   <= `CSIE_SP_RESET;
      s_reg.rd   <= 1'b1;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  assign bus_addr       = s_reg.addr;
  assign bus_wdata      = s_reg.wdata;
  assign bus_rd         = s_reg.rd;
  assign bus_wr         = s_reg.wr;
  assign bus_rmw        = s_reg.read_modify_write_marker;
  assign port_latch_out = s_reg.latch;
  assign irq_flag_out   = s_reg.irq;
endmodule : csie_core
`default_nettype wire

//--- csie_core_props.sv
`timescale 1ns/1ps
`default_nettype none
module csie_core_props (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic [15:0] bus_addr,
  input wire logic [7:0]  bus_wdata,
  input wire logic        bus_rd,
  input wire logic        bus_wr,
  input wire logic        bus_rmw,
  input wire logic [7:0]  bus_rdata,
  input wire logic [7:0]  port_latch_out,
  input wire logic [7:0]  irq_set,
  input wire logic [7:0]  irq_flag_out
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  logic [7:0] rd_q0, rd_q1, rd_q2, rv_q;
  // what the bit op should have read: latch for the port, all ones for flags
  wire  [7:0] rv = (bus_addr == 16'h0000) ? port_latch_out : (bus_addr == 16'h0001) ? 8'hFF : bus_rdata;
  wire  [7:0] msk = 8'h01 << rd_q2[2:0];
  wire  [7:0] bit_exp = rd_q2[3] ? (rv_q | msk) : (rv_q & ~msk);
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      rd_q0 <= 8'h00;
      rd_q1 <= 8'h00;
      rd_q2 <= 8'h00;
      rv_q  <= 8'h00;
    end
    else
    begin
      rd_q0 <= bus_rdata;
      rd_q1 <= rd_q0;
      rd_q2 <= rd_q1;
      rv_q  <= rv;
    end
  end
  sequence s_rmw_pair;
    bus_rmw ##1 (bus_wr && !bus_rd);
  endsequence
  sequence s_push;
    $rose(bus_wr) ##1 bus_wr;
  endsequence
  property p_rmw_order;
    bus_rmw |=> (bus_wr && !bus_rd && bus_addr == $past(bus_addr))
      ##1 (bus_rd && !bus_rmw && bus_addr == $past(bus_addr, 3) + 16'h0001);
  endproperty
  property p_rmw_page0;
    bus_rmw |-> bus_rd && !bus_wr && bus_addr == {8'h00, $past(bus_rdata)};
  endproperty
  property p_bit_write;
    s_rmw_pair |-> bus_wdata == bit_exp;
  endproperty
  property p_latch_write;
    (bus_wr && bus_addr == 16'h0000) |=> port_latch_out == $past(bus_wdata);
  endproperty
  property p_irq_set;
    (irq_set != 8'h00) |=> (irq_flag_out & $past(irq_set)) == $past(irq_set);
  endproperty
  property p_irq_keep;
    !(bus_wr && bus_addr == 16'h0001) |=> irq_flag_out == ($past(irq_flag_out) | $past(irq_set));
  endproperty
  property p_vec_read;
    (bus_rd && bus_addr[15:4] == 12'hFFC && !bus_addr[0]) |=> (bus_rd && bus_addr == $past(bus_addr) + 16'h0001)
      ##1 bus_addr == {$past(bus_rdata, 2), $past(bus_rdata)};
  endproperty
  property p_push;
    s_push |-> ({$past(bus_wdata), bus_wdata} == $past(bus_addr, 2) + 16'h0001
      && bus_addr == $past(bus_addr) + 16'h0001) ##1 (bus_rd && bus_addr == {12'hFFC, rd_q2[2:0], 1'b0});
  endproperty
  property p_idle_data;
    !bus_wr |-> bus_wdata == 8'h00 && !bus_rmw | bus_rd;
  endproperty
  a_rmw_order: assert property (p_rmw_order)
    else $error("bit op bus order wrong");
  a_rmw_page0: assert property (p_rmw_page0)
    else $error("bit op read not at page zero operand");
  a_bit_write: assert property (p_bit_write)
    else $error("bit op write data wrong");
  a_latch_write: assert property (p_latch_write)
    else $error("port latch not updated");
  a_irq_set: assert property (p_irq_set)
    else $error("irq request lost");
  a_irq_keep: assert property (p_irq_keep)
    else $error("irq flags changed without write");
  a_vec_read: assert property (p_vec_read)
    else $error("vector table branch wrong");
  a_push: assert property (p_push)
    else $error("vector call push wrong");
  a_idle_data: assert property (p_idle_data)
    else $error("idle bus cycle shows data");
endmodule : csie_core_props
bind csie_core csie_core_props csie_core_props_i (.clk(clk), .rst(rst), .bus_addr(bus_addr),
  .bus_wdata(bus_wdata), .bus_rd(bus_rd), .bus_wr(bus_wr), .bus_rmw(bus_rmw), .bus_rdata(bus_rdata),
  .port_latch_out(port_latch_out), .irq_set(irq_set), .irq_flag_out(irq_flag_out));
`default_nettype wire

//--- csie_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module csie_mem_model (
  input  wire logic        clk,
  input  wire logic [15:0] bus_addr,
  input  wire logic [7:0]  bus_wdata,
  input  wire logic        bus_rd,
  input  wire logic        bus_wr,
  output logic [7:0]       bus_rdata
);
  logic [7:0] mem [0:65535];
  logic [7:0] last_reg = 8'h00;
  // zero wait; off read cycles the data lines show the complement of the last read value, never the value itself
  assign bus_rdata = bus_rd ? mem[bus_addr] : ~last_reg;
  always @(posedge clk)
  begin
    if (bus_wr)
      mem[bus_addr] <= bus_wdata;
    if (bus_rd)
      last_reg <= bus_rdata;
  end
endmodule : csie_mem_model
`default_nettype wire

//--- cpu_special_instr_exec_tb.sv
`timescale 1ns/1ps
`default_nettype none
module cpu_special_instr_exec_tb;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [15:0] bus_addr;
  logic [7:0]  bus_wdata, bus_rdata, port_latch_out, irq_flag_out;
  logic [7:0]  port_pin_in = 8'hE8;
  logic [7:0]  irq_set = 8'h00;
  logic        bus_rd, bus_wr, bus_rmw;
  int          fails = 0;
  int          checks_done = 0;
  always #20 clk = ~clk;
  csie_core csie_core_i (.clk(clk), .rst(rst), .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_rd(bus_rd),
    .bus_wr(bus_wr), .bus_rmw(bus_rmw), .bus_rdata(bus_rdata), .port_pin_in(port_pin_in),
    .port_latch_out(port_latch_out), .irq_set(irq_set), .irq_flag_out(irq_flag_out));
  csie_mem_model csie_mem_model_i (.clk(clk), .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_rd(bus_rd),
    .bus_wr(bus_wr), .bus_rdata(bus_rdata));
  task automatic stop_test;
    if (fails == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : stop_test
  task automatic chk(string nm, logic [26:0] e, logic [26:0] g);
    checks_done++;
    if (g !== e)
    begin
      fails++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic load(logic [15:0] a, logic [7:0] b[]);
    foreach (b[i]) csie_mem_model_i.mem[a + 16'(i)] = b[i];
  endtask : load
  task automatic cyc(logic [15:0] a, logic r, logic w, logic m, logic [7:0] d);
    @(negedge clk);
    chk("bus cycle", {a, r, w, m, d}, {bus_addr, bus_rd, bus_wr, bus_rmw, bus_wdata});
  endtask : cyc
  task automatic rdc(logic [15:0] a);
    cyc(a, 1'b1, 1'b0, 1'b0, 8'h00);
  endtask : rdc
  task automatic read_modify_write_marker(logic [15:0] a, logic [7:0] d);
    cyc(a, 1'b1, 1'b0, 1'b1, 8'h00);
    cyc(a, 1'b0, 1'b1, 1'b0, d);
  endtask : read_modify_write_marker
  task automatic trace(logic [15:0] s[]);
    foreach (s[i]) rdc(s[i]);
  endtask : trace
  // every scenario enters its code through a vector call made from address 0000
  task automatic boot(logic [2:0] v, logic [15:0] t);
    logic [15:0] va;
    va = 16'hFFC0 + {12'h000, v, 1'b0};
    csie_mem_model_i.mem[16'h0000] = {5'h1D, v};
    load(va, '{t[15:8], t[7:0]});
    port_pin_in = {5'h1D, v};
    rst = 1'b1;
    repeat (5) @(negedge clk);
    rst = 1'b0;
    cyc(16'h027E, 1'b0, 1'b1, 1'b0, 8'h00);
    cyc(16'h027F, 1'b0, 1'b1, 1'b0, 8'h01);
    trace('{va, va + 16'h0001, t});
  endtask : boot
  task automatic wait_fetch(logic [15:0] a);
    for (int n = 0; n < 60 && !(bus_rd === 1'b1 && bus_addr === a); n++) @(negedge clk);
    if (!(bus_rd === 1'b1 && bus_addr === a))
    begin
      fails++;
      $display("mismatch fetch wait expected %h seen %h", a, bus_addr);
      stop_test();
    end
  endtask : wait_fetch
  task automatic t_vector_call;
    for (int v = 0; v < 8; v++) boot(3'(v), {8'h10 + 8'(v), 8'h20});
  endtask : t_vector_call
  task automatic t_bits;
    logic [7:0] v, nv, op;
    v = 8'h5A;
    csie_mem_model_i.mem[16'h0040] = v;
    for (int i = 0; i < 16; i++) load(16'h0200 + 16'(2 * i), '{8'hA0 | 8'(i ^ 8), 8'h40});
    boot(3'h0, 16'h0200);
    for (int i = 0; i < 16; i++)
    begin
      op = 8'hA0 | 8'(i ^ 8);
      nv = op[3] ? (v | (8'h01 << op[2:0])) : (v & ~(8'h01 << op[2:0]));
      rdc(16'h0201 + 16'(2 * i));
      read_modify_write_marker(16'h0040, nv);
      rdc(16'h0202 + 16'(2 * i));
      v = nv;
    end
  endtask : t_bits
  task automatic t_port_irq;
    load(16'h0240, '{8'hA9, 8'h00, 8'hA0, 8'h01, 8'hA6, 8'h01, 8'hE4, 8'h06, 8'h00, 8'h05, 8'h00, 8'hE0});
    boot(3'h1, 16'h0240);
    port_pin_in = 8'h3C;
    irq_set = 8'h40;
    rdc(16'h0241);
    irq_set = 8'h00;
    read_modify_write_marker(16'h0000, 8'h02);
    rdc(16'h0242);
    chk("port latch", 27'h02, {19'h0, port_latch_out});
    rdc(16'h0243);
    read_modify_write_marker(16'h0001, 8'hFE);
    rdc(16'h0244);
    chk("irq flags", 27'h40, {19'h0, irq_flag_out});
    rdc(16'h0245);
    read_modify_write_marker(16'h0001, 8'hBF);
    rdc(16'h0246);
    chk("irq flags", 27'h00, {19'h0, irq_flag_out});
    // plain read of the port shows the pins, so the jump lands at 06:pins
    trace('{16'h0247, 16'h0248, 16'h0249, 16'h024A, 16'h0000, 16'h024B, 16'h063C});
  endtask : t_port_irq
  task automatic t_branch;
    load(16'h0300, '{8'h04, 8'h00, 8'hFD, 8'hF0});
    load(16'h02F4, '{8'hFC, 8'h7F, 8'h04, 8'h01, 8'hFC, 8'h7F});
    load(16'h0379, '{8'hFC, 8'h80});
    boot(3'h2, 16'h0300);
    trace('{16'h0301, 16'h0302, 16'h0303, 16'h02F4, 16'h02F5, 16'h02F6, 16'h02F7, 16'h02F8, 16'h02F9,
            16'h0379, 16'h037A, 16'h02FB});
  endtask : t_branch
  task automatic t_jumps;
    load(16'h0400, '{8'hE4, 8'h05, 8'h00, 8'hF4, 8'hF0, 8'hE0});
    load(16'h0500, '{8'hE0});
    boot(3'h3, 16'h0400);
    trace('{16'h0401, 16'h0402, 16'h0403, 16'h0500, 16'h0404, 16'h0405, 16'h0405});
  endtask : t_jumps
  task automatic t_muldiv;
    logic [15:0] p, q;
    p = 16'h000D * 16'h000F;
    q = (p / 16'h0007) * (p % 16'h0007);
    load(16'h0600, '{8'h04, 8'h0D, 8'h04, 8'h0F, 8'h01, 8'hE0});
    load(p, '{8'h04, 8'h07, 8'h11, 8'h01, 8'hE0});
    boot(3'h4, 16'h0600);
    wait_fetch(16'h0605);
    rdc(p);
    wait_fetch(p + 16'h0004);
    rdc(q);
  endtask : t_muldiv
  initial
  begin
    t_vector_call();
    t_bits();
    t_port_irq();
    t_branch();
    t_jumps();
    t_muldiv();
    stop_test();
  end
endmodule : cpu_special_instr_exec_tb
`default_nettype wire
